/* File: bench/els_lan_peer.sv */
// link partner model: negotiates speed and duplex, shows activity
`timescale 1ns/1ps

module els_lan_peer
	import els_pkg::*;
(
	input wire logic mclk_in,
	input wire logic [4:0] cfg_in,
	input wire logic [7:0] tcp_in,
	output els_phy_s phy_out,
	output logic [7:0] tcp_out
);
	always @(posedge mclk_in) begin
		phy_out.link <= cfg_in[4];
		// the far end only resolves a mode while the link is up
		if (cfg_in[4]) begin
			phy_out.full_dup <= cfg_in[3];
			phy_out.spd100 <= cfg_in[2];
		end
		// no frames move on a dead link
		phy_out.rx_act <= cfg_in[4] & cfg_in[1];
		phy_out.tx_act <= cfg_in[4] & cfg_in[0];
		tcp_out <= tcp_in;
	end
endmodule

/* File: bench/els_tb.sv */
// self-checking bench of the link status block
`timescale 1ns/1ps
`include "els_consts.svh"

module testbench;
	import els_pkg::*;
	logic mclk_in = 0;
	logic rst_in = 1;
	logic [4:0] cfg = 5'h00;
	logic [7:0] tcp = 8'h00;
	els_phy_s phy;
	logic [7:0] tcp_w;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 0;
	logic rd = 0;
	logic req = 0;
	logic [31:0] dest = 32'h0;
	logic [31:0] rdata;
	logic [31:0] hop;
	logic [15:0] status;
	logic valid;
	logic allow;
	logic irq;
	logic [31:0] seed = 32'h96DA;
	logic hd = 0;
	logic hs = 0;
	logic [7:0] cnt;
	int fail_count = 0;
	int checks = 0;
	logic [31:0] exp_q[$];

	always #12.5 mclk_in = ~mclk_in;

	els_lan_peer i_els_lan_peer (.mclk_in(mclk_in), .cfg_in(cfg),
		.tcp_in(tcp), .phy_out(phy), .tcp_out(tcp_w));

	els_link_status i_els_link_status (.mclk_in(mclk_in), .rst_in(rst_in),
		.phy_link_up_in(phy.link), .phy_full_duplex_in(phy.full_dup),
		.phy_speed100_in(phy.spd100), .phy_rx_active_in(phy.rx_act),
		.phy_tx_active_in(phy.tx_act), .tcp_sessions_in(tcp_w),
		.addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
		.rdata_out(rdata), .route_req_in(req), .dest_ip_in(dest),
		.route_valid_out(valid), .route_allow_out(allow),
		.next_hop_out(hop), .status_out(status), .irq_out(irq));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %0t got %h want %h", $time, got, exp);
		end
	endtask

	task automatic close_out();
		if (fail_count == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		wr <= 1'h1;
		addr <= a;
		wdata <= d;
		@(posedge mclk_in);
		wr <= 1'h0;
	endtask

	task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
		@(posedge mclk_in);
		rd <= 1'h1;
		addr <= a;
		exp_q.push_back(e);
		@(posedge mclk_in);
		rd <= 1'h0;
		#1 chk(rdata, exp_q.pop_front());
	endtask

	// write and read back on the very next cycle, no idle cycle between
	task automatic wr_rd(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		wr <= 1'h1;
		addr <= a;
		wdata <= d;
		exp_q.push_back(d);
		@(posedge mclk_in);
		wr <= 1'h0;
		rd <= 1'h1;
		@(posedge mclk_in);
		rd <= 1'h0;
		#1 chk(rdata, exp_q.pop_front());
	endtask

	task automatic route(input logic [31:0] d, input logic a,
		input logic [31:0] h);
		@(posedge mclk_in);
		req <= 1;
		dest <= d;
		@(posedge mclk_in);
		req <= 0;
		#1 chk({31'h0, valid}, 32'h1);
		chk({31'h0, allow}, {31'h0, a});
		chk(hop, h);
	endtask

	initial begin
		logic [31:0] ipv;
		repeat (5) @(posedge mclk_in);
		rst_in <= 0;
		rd_reg(`ELS_OFF_MASK, `ELS_MASK_RST);
		rd_reg(`ELS_OFF_GATEWAY, 32'h0);
		rd_reg(`ELS_OFF_VERSION, 32'h01AE);
		rd_reg(8'h1C, 32'h0);
		for (int i = 0; i < 24; i++) begin
			cfg <= (i < 2) ? 5'h1F : 5'(rnd());
			tcp <= 8'(rnd() % 32'h40);
			repeat (6) @(posedge mclk_in);
			if (cfg[4]) begin
				hd = cfg[3];
				hs = cfg[2];
			end
			cnt = (tcp > `ELS_TCP_MAX) ? `ELS_TCP_MAX : tcp;
			rd_reg(`ELS_OFF_STATUS, {18'h0, hd, hs, 1'b0,
				cfg[4] & cfg[1], cfg[4] & cfg[0], cfg[4], cnt});
			chk({16'h0, status}, rdata);
		end
		ipv = rnd();
		wr_rd(`ELS_OFF_IP, ipv);
		wr_reg(`ELS_OFF_STATUS, 32'hFFFF);
		wr_reg(`ELS_OFF_VERSION, 32'h0);
		rd_reg(`ELS_OFF_IP, ipv);
		rd_reg(`ELS_OFF_VERSION, 32'h01AE);
		wr_reg(`ELS_OFF_IRQ_MASK, 32'h8);
		wr_reg(`ELS_OFF_IRQ_STAT, 32'hF);
		rd_reg(`ELS_OFF_IRQ_STAT, 32'h0);
		route(ipv ^ 32'h0000_0055, 1'h1, ipv ^ 32'h0000_0055);
		route(ipv ^ 32'h0100_0000, 1'h0, 32'h0);
		@(posedge mclk_in);
		#1 chk({31'h0, irq}, 32'h1);
		wr_reg(`ELS_OFF_IRQ_STAT, 32'h8);
		@(posedge mclk_in);
		#1 chk({31'h0, irq}, 32'h0);
		wr_reg(`ELS_OFF_GATEWAY, ipv ^ 32'h1);
		route(ipv ^ 32'h0100_0000, 1'h1, ipv ^ 32'h1);
		wr_reg(`ELS_OFF_MASK, 32'hFFFF0000);
		rd_reg(`ELS_OFF_MASK, 32'hFFFF0000);
		route(ipv ^ 32'h0000_5500, 1'h1, ipv ^ 32'h0000_5500);
		close_out();
	end

	initial begin
		#200000;
		fail_count++;
		close_out();
	end
endmodule

/* File: design/els_consts.svh */
// register offsets, field positions and reset values of the link status block
`ifndef ELS_CONSTS_SVH
`define ELS_CONSTS_SVH

`define ELS_ADDR_W 8
`define ELS_DATA_W 32

`define ELS_OFF_STATUS 8'h00
`define ELS_OFF_VERSION 8'h04
`define ELS_OFF_IP 8'h08
`define ELS_OFF_MASK 8'h0C
`define ELS_OFF_GATEWAY 8'h10
`define ELS_OFF_IRQ_STAT 8'h14
`define ELS_OFF_IRQ_MASK 8'h18

`define ELS_BIT_RSV16 15
`define ELS_BIT_RSV15 14
`define ELS_BIT_DUP 13
`define ELS_BIT_SPD 12
`define ELS_BIT_RSV12 11
`define ELS_BIT_RX 10
`define ELS_BIT_TX 9
`define ELS_BIT_LINK 8
`define ELS_TCP_MSB 7

`define ELS_TCP_MAX 8'h28

`define ELS_IP_RST 32'h00000000
`define ELS_MASK_RST 32'hFFFFFF00
`define ELS_GW_RST 32'h00000000

`define ELS_IRQ_W 4
`define ELS_IRQ_LINK 0
`define ELS_IRQ_MODE 1
`define ELS_IRQ_TCP 2
`define ELS_IRQ_OFFNET 3

`endif

/* File: design/els_link_status.sv */
// ethernet port status word, version word and static address settings
`timescale 1ns/1ps
`include "els_consts.svh"

module els_link_status
	import els_pkg::*;
#(
	parameter logic [15:0] FW_VERSION_X100 = 16'h01AE
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic phy_link_up_in,
	input wire logic phy_full_duplex_in,
	input wire logic phy_speed100_in,
	input wire logic phy_rx_active_in,
	input wire logic phy_tx_active_in,
	input wire logic [7:0] tcp_sessions_in,
	input wire logic [`ELS_ADDR_W-1:0] addr_in,
	input wire logic [`ELS_DATA_W-1:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [`ELS_DATA_W-1:0] rdata_out,
	input wire logic route_req_in,
	input wire logic [31:0] dest_ip_in,
	output logic route_valid_out,
	output logic route_allow_out,
	output logic [31:0] next_hop_out,
	output logic [15:0] status_out,
	output logic irq_out
);

	localparam els_state_s ST_RST = '{
		ip: `ELS_IP_RST,
		mask: `ELS_MASK_RST,
		gw: `ELS_GW_RST,
		default: '0
	};

	els_state_s q;
	els_state_s d;

	function automatic logic hit(
		input logic [`ELS_ADDR_W-1:0] a,
		input logic [`ELS_ADDR_W-1:0] off
	);
		hit = (a == off);
	endfunction

	logic [7:0] tcp_clamped;
	logic on_subnet;
	logic gw_zero;
	logic [`ELS_IRQ_W-1:0] events;
	logic [`ELS_IRQ_W-1:0] w1c;

	always_comb begin
		d = q;
		tcp_clamped = 8'h00;
		on_subnet = 1'b0;
		gw_zero = 1'b0;
		events = '0;
		w1c = '0;

		// phy pins are asynchronous; the first stage feeds only the second
		d.sync1 = '{
			link: phy_link_up_in,
			full_dup: phy_full_duplex_in,
			spd100: phy_speed100_in,
			rx_act: phy_rx_active_in,
			tx_act: phy_tx_active_in
		};
		d.sync2 = q.sync1;

		// status word rebuilt every cycle from synchronised phy inputs and the unsynchronised session count, except the mode bits while link is down
		d.status[`ELS_BIT_RSV16] = 1'b0;
		d.status[`ELS_BIT_RSV15] = 1'b0;
		d.status[`ELS_BIT_RSV12] = 1'b0;
		// negotiated mode is only meaningful with link up; hold it while down
		if (q.sync2.link) begin
			d.status[`ELS_BIT_DUP] = q.sync2.full_dup;
			d.status[`ELS_BIT_SPD] = q.sync2.spd100;
		end
		d.status[`ELS_BIT_RX] = q.sync2.rx_act;
		d.status[`ELS_BIT_TX] = q.sync2.tx_act;
		d.status[`ELS_BIT_LINK] = q.sync2.link;
		// counts above the session limit are a source fault; clamp, not wrap
		if (tcp_sessions_in > `ELS_TCP_MAX) begin
			tcp_clamped = `ELS_TCP_MAX;
		end else begin
			tcp_clamped = tcp_sessions_in;
		end
		d.status[`ELS_TCP_MSB:0] = tcp_clamped;

		// change events; activity bits toggle per frame and raise none
		events[`ELS_IRQ_LINK] =
			d.status[`ELS_BIT_LINK] != q.status[`ELS_BIT_LINK];
		events[`ELS_IRQ_MODE] =
			(d.status[`ELS_BIT_DUP] != q.status[`ELS_BIT_DUP]) ||
			(d.status[`ELS_BIT_SPD] != q.status[`ELS_BIT_SPD]);
		events[`ELS_IRQ_TCP] =
			d.status[`ELS_TCP_MSB:0] != q.status[`ELS_TCP_MSB:0];

		// next-hop decision for outgoing traffic
		on_subnet = ((dest_ip_in ^ q.ip) & q.mask) == 32'h00000000;
		gw_zero = q.gw == `ELS_GW_RST;
		d.route_valid = route_req_in;
		d.route_allow = route_req_in && (on_subnet || !gw_zero);
		d.next_hop = on_subnet ? dest_ip_in : q.gw;
		events[`ELS_IRQ_OFFNET] = route_req_in && !on_subnet && gw_zero;

		// register writes; read-only words ignore writes
		if (wr_in) begin
			if (hit(addr_in, `ELS_OFF_IP)) begin
				d.ip = wdata_in;
			end
			if (hit(addr_in, `ELS_OFF_MASK)) begin
				d.mask = wdata_in;
			end
			if (hit(addr_in, `ELS_OFF_GATEWAY)) begin
				d.gw = wdata_in;
			end
			if (hit(addr_in, `ELS_OFF_IRQ_STAT)) begin
				w1c = wdata_in[`ELS_IRQ_W-1:0];
			end
			if (hit(addr_in, `ELS_OFF_IRQ_MASK)) begin
				d.irq_mask = wdata_in[`ELS_IRQ_W-1:0];
			end
		end
		// an event in the clearing cycle survives the clear
		d.irq_stat = (q.irq_stat & ~w1c) | events;

		// read data stands only in the cycle after the strobe
		d.rdata = '0;
		if (rd_in) begin
			if (hit(addr_in, `ELS_OFF_STATUS)) begin
				d.rdata = {16'h0000, q.status};
			end else if (hit(addr_in, `ELS_OFF_VERSION)) begin
				d.rdata = {16'h0000, FW_VERSION_X100};
			end else if (hit(addr_in, `ELS_OFF_IP)) begin
				d.rdata = q.ip;
			end else if (hit(addr_in, `ELS_OFF_MASK)) begin
				d.rdata = q.mask;
			end else if (hit(addr_in, `ELS_OFF_GATEWAY)) begin
				d.rdata = q.gw;
			end else if (hit(addr_in, `ELS_OFF_IRQ_STAT)) begin
				d.rdata = {28'h0000000, q.irq_stat};
			end else if (hit(addr_in, `ELS_OFF_IRQ_MASK)) begin
				d.rdata = {28'h0000000, q.irq_mask};
			end
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			q <= ST_RST;
		end else begin
			q <= d;
		end
	end

	assign rdata_out = q.rdata;
	assign route_valid_out = q.route_valid;
	assign route_allow_out = q.route_allow;
	assign next_hop_out = q.next_hop;
	assign status_out = q.status;
	assign irq_out = |(q.irq_stat & q.irq_mask);

	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (rst_in);

	rsvd_bits_zero_a: assert property (
		q.status[`ELS_BIT_RSV16] == 1'b0 &&
		q.status[`ELS_BIT_RSV15] == 1'b0 &&
		q.status[`ELS_BIT_RSV12] == 1'b0)
		else $error("reserved status bit set");

	duplex_track_a: assert property (
		q.sync2.link ##1 1'b1 |->
		q.status[`ELS_BIT_DUP] == $past(q.sync2.full_dup))
		else $error("duplex bit does not follow negotiation");

	speed_track_a: assert property (
		q.sync2.link |=>
		q.status[`ELS_BIT_SPD] == $past(q.sync2.spd100))
		else $error("speed bit does not follow negotiation");

	activity_bits_a: assert property (
		##1 q.status[`ELS_BIT_RX:`ELS_BIT_LINK] ==
		$past({q.sync2.rx_act, q.sync2.tx_act, q.sync2.link}))
		else $error("activity bits wrong");

	pin_to_status_a: assert property (
		$rose(phy_link_up_in) ##1 phy_link_up_in ##1 phy_link_up_in
		|=> q.status[`ELS_BIT_LINK])
		else $error("link pin not seen after three cycles");

	tcp_clamp_a: assert property (
		##1 q.status[`ELS_TCP_MSB:0] ==
		(($past(tcp_sessions_in) > `ELS_TCP_MAX) ?
		`ELS_TCP_MAX : $past(tcp_sessions_in)))
		else $error("session count wrong or unclamped");

	version_read_a: assert property (
		rd_in && addr_in == `ELS_OFF_VERSION |=>
		rdata_out == {16'h0000, FW_VERSION_X100})
		else $error("version word wrong");

	mode_hold_a: assert property (
		!q.sync2.link |=>
		$stable(q.status[`ELS_BIT_DUP:`ELS_BIT_SPD]))
		else $error("mode changed while link down");

	ip_store_a: assert property (
		wr_in && addr_in == `ELS_OFF_IP ##1 rd_in &&
		addr_in == `ELS_OFF_IP |=> rdata_out == $past(wdata_in, 2))
		else $error("address octets not kept");

	offnet_block_a: assert property (
		route_req_in && q.gw == `ELS_GW_RST &&
		(((dest_ip_in ^ q.ip) & q.mask) != 32'h00000000)
		|=> route_valid_out && !route_allow_out &&
		q.irq_stat[`ELS_IRQ_OFFNET])
		else $error("off-subnet traffic allowed without gateway");

	mask_reset_a: assert property (
		$fell(rst_in) |-> q.mask == `ELS_MASK_RST && q.gw == `ELS_GW_RST)
		else $error("mask or gateway reset value wrong");

	link_event_a: assert property (
		$changed(q.status[`ELS_BIT_LINK]) |->
		q.irq_stat[`ELS_IRQ_LINK])
		else $error("link change did not flag");

	// without a write the status only grows and the mask stands still
	irq_level_a: assert property (
		(irq_out || |(events & q.irq_mask)) && !wr_in |=> irq_out)
		else $error("interrupt level wrong");

	read_idle_zero_a: assert property (
		!rd_in |=> rdata_out == 32'h00000000)
		else $error("read data outside its cycle");

	status_read_a: assert property (
		rd_in && addr_in == `ELS_OFF_STATUS |=>
		rdata_out == {16'h0000, $past(q.status)})
		else $error("status word read wrong");

	route_pulse_a: assert property (
		##1 route_valid_out == $past(route_req_in))
		else $error("route answer not one cycle after request");

	onnet_allow_a: assert property (
		route_req_in &&
		(((dest_ip_in ^ q.ip) & q.mask) == 32'h00000000) |=>
		route_allow_out && next_hop_out == $past(dest_ip_in))
		else $error("on-subnet traffic not sent direct");

	gw_route_a: assert property (
		route_req_in && q.gw != `ELS_GW_RST &&
		(((dest_ip_in ^ q.ip) & q.mask) != 32'h00000000) |=>
		route_allow_out && next_hop_out == $past(q.gw))
		else $error("off-subnet traffic not sent to gateway");

	gw_store_a: assert property (
		wr_in && addr_in == `ELS_OFF_GATEWAY |=>
		q.gw == $past(wdata_in))
		else $error("gateway write lost");

	mask_store_a: assert property (
		wr_in && addr_in == `ELS_OFF_MASK |=>
		q.mask == $past(wdata_in))
		else $error("mask write lost");

	set_wins_a: assert property (
		|events |=> (q.irq_stat & $past(events)) == $past(events))
		else $error("event lost in clearing cycle");

	w1c_clear_a: assert property (
		wr_in && addr_in == `ELS_OFF_IRQ_STAT && events == '0 |=>
		(q.irq_stat & $past(wdata_in[`ELS_IRQ_W-1:0])) == '0)
		else $error("write one did not clear status");

	mode_event_a: assert property (
		$changed(q.status[`ELS_BIT_DUP:`ELS_BIT_SPD]) |->
		q.irq_stat[`ELS_IRQ_MODE])
		else $error("mode change did not flag");

	tcp_event_a: assert property (
		$changed(q.status[`ELS_TCP_MSB:0]) |->
		q.irq_stat[`ELS_IRQ_TCP])
		else $error("session count change did not flag");

	link_up_full_c: cover property (
		$rose(q.status[`ELS_BIT_LINK]) && q.sync2.full_dup && q.sync2.spd100);
	tcp_max_c: cover property (q.status[`ELS_TCP_MSB:0] == `ELS_TCP_MAX);
	offnet_c: cover property (route_valid_out && !route_allow_out);
	clear_race_c: cover property (
		wr_in && addr_in == `ELS_OFF_IRQ_STAT && |events);

endmodule

/* File: design/els_pkg.sv */
// types of the link status block
package els_pkg;

	typedef struct packed {
		logic link;
		logic full_dup;
		logic spd100;
		logic rx_act;
		logic tx_act;
	} els_phy_s;

	typedef struct packed {
		els_phy_s sync1;
		els_phy_s sync2;
		logic [15:0] status;
		logic [31:0] ip;
		logic [31:0] mask;
		logic [31:0] gw;
		logic [3:0] irq_stat;
		logic [3:0] irq_mask;
		logic [31:0] rdata;
		logic route_valid;
		logic route_allow;
		logic [31:0] next_hop;
	} els_state_s;

endpackage
